// ===== design/rbls_rate_select.sv
// rate select block: slot registers, pin driven slot choice and effective settings
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - swing code 00=350, 01/10=650, 11=850 mVpp
// - bw slot A: override uses field, else 2.4GHz
// - both pins low select bw slot A
// - bw slot B: override uses field, else 7.6GHz
// - upper low, lower high select bw B
// - bw slot C: override uses field, else 8.4GHz
// - both pins high select bw slot C
// - bw slot D: override uses field, else 9.0GHz
// - upper high lower low, or floating, select D
// - loss override: seven bits set assert level
// - loss slot A default is 15 mVpp
// - both pins low select loss slot A
// - loss slot B default is 18 mVpp
// - upper low, lower high select loss B
// - loss slot C default is 26 mVpp
// - both pins high select loss slot C
// - upper high lower low select loss D, 26mV
// - read-only field shows effective bandwidth code
// - read-only field shows effective loss level
module rbls_rate_select
    import rbls_pkg::*;
#(
    parameter logic [RBLS_BW_W-1:0]   BW_DEF_CODE   = '0, // code reported while a bw default applies
    parameter logic [RBLS_LOSS_W-1:0] LOSS_DEF_CODE = '0  // code reported while a loss default applies
) (
    input  wire logic                    ref_clk_i,          // 20 MHz clock
    input  wire logic                    reset_n_i,          // async reset, active low
    input  wire logic                    ce_i,               // clock enable, freezes all state when low
    input  wire logic                    speed_pin_upper_i,  // rate select pin, upper
    input  wire logic                    speed_pin_lower_i,  // rate select pin, lower
    input  wire logic [7:0]              reg_addr_i,         // register offset
    input  wire logic                    reg_wr_i,           // write strobe
    input  wire logic [7:0]              reg_wdata_i,        // write data
    output logic      [7:0]              reg_rdata_o,        // read data, one cycle after address
    output logic      [RBLS_SWING_W-1:0] swing_code_o,       // output swing code in effect
    output logic      [9:0]              swing_mv_o,         // output swing in mVpp
    output logic      [RBLS_BW_W-1:0]    effective_bw_field_o,         // bw code in effect
    output logic                         bw_default_o,                 // fixed default bw applies
    output logic      [13:0]             bw_default_mhz_o,             // default bw of chosen slot
    output logic      [RBLS_LOSS_W-1:0]  effective_loss_level_field_o, // loss level code in effect
    output logic                         loss_default_o,               // fixed default loss level applies
    output logic      [5:0]              loss_default_mv_o,            // default loss level of chosen slot
    output logic      [1:0]              active_slot_o                 // slot chosen by the pins
);

    // elaboration checks: two select pins address exactly four slots
    if (RBLS_SLOTS != 4) begin : g_bad_slots
        $error("rbls_rate_select: four slots required");
    end
    // the override flag must sit above both code fields inside one byte
    if (RBLS_OVR_BIT > 7 || RBLS_BW_W > RBLS_OVR_BIT || RBLS_LOSS_W > RBLS_OVR_BIT) begin : g_bad_fields
        $error("rbls_rate_select: code field overlaps the override flag");
    end
    // the low address bits index a bank, so each bank starts on a four byte boundary
    if (RBLS_OFS_BW_A[1:0] != 2'b00 || RBLS_OFS_LOSS_A[1:0] != 2'b00) begin : g_bad_align
        $error("rbls_rate_select: slot bank not aligned");
    end
    // each bank holds exactly one register per slot
    if ((RBLS_OFS_BW_D - RBLS_OFS_BW_A) != 8'(RBLS_SLOTS - 1)
        || (RBLS_OFS_LOSS_D - RBLS_OFS_LOSS_A) != 8'(RBLS_SLOTS - 1)) begin : g_bad_span
        $error("rbls_rate_select: slot bank span wrong");
    end
    // the swing field must fit the level decode below
    if (RBLS_SWING_W != 2) begin : g_bad_swing
        $error("rbls_rate_select: two bit swing field required");
    end

    logic [7:0]              bw_slot_r [RBLS_SLOTS];   // bandwidth slot registers A..D
    logic [7:0]              loss_slot_r [RBLS_SLOTS]; // loss level slot registers A..D
    logic [7:0]              swing_r;                  // swing register, low two bits used
    logic [1:0]              pin_meta_r;               // first synchroniser stage
    logic [1:0]              pin_sync_r;               // second synchroniser stage
    rbls_slot_e              slot;                     // slot from synchronised pins
    logic [7:0]              bw_sel;                   // chosen bandwidth slot register
    logic [7:0]              loss_sel;                 // chosen loss slot register
    logic [RBLS_BW_W-1:0]    bw_nxt;                   // next effective bw code
    logic [RBLS_LOSS_W-1:0]  loss_nxt;                 // next effective loss code
    logic [13:0]             bw_def_nxt;               // default bw of chosen slot
    logic [5:0]              loss_def_nxt;             // default loss level of chosen slot
    logic [9:0]              swing_mv_nxt;             // next swing level
    logic [7:0]              rdata_nxt;                // next read data
    // shared address decode and bank selection
    logic [1:0]              bank_idx;                 // bank register of the chosen slot
    logic                    wr_en;                    // write strobe qualified by the clock enable
    logic                    sel_swing;                // swing register addressed
    logic                    sel_bw;                   // bandwidth bank addressed
    logic                    sel_loss;                 // loss bank addressed
    logic                    sel_eff_bw;               // effective bandwidth field addressed
    logic                    sel_eff_loss;             // effective loss field addressed

    // map the synchronised pin pair onto a slot
    function automatic rbls_slot_e pin_slot(input logic [1:0] pins);
        rbls_slot_e s;
        s = RBLS_SLOT_D;
        case (pins)
            2'b00:   s = RBLS_SLOT_A;
            2'b01:   s = RBLS_SLOT_B;
            2'b11:   s = RBLS_SLOT_C;
            default: s = RBLS_SLOT_D;
        endcase
        return s;
    endfunction

    // true when an offset lies inside a four register slot bank
    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // bank index of a slot: the slot code follows the pin pair (D is 10, C is 11),
    // while the banks are laid out A, B, C, D by address, so C and D trade places here;
    // indexing a bank with the raw slot code would apply the wrong register
    function automatic logic [1:0] slot_idx(input rbls_slot_e s);
        logic [1:0] idx;
        idx = RBLS_IDX_D;
        case (s)
            RBLS_SLOT_A: idx = RBLS_IDX_A;
            RBLS_SLOT_B: idx = RBLS_IDX_B;
            RBLS_SLOT_C: idx = RBLS_IDX_C;
            default:     idx = RBLS_IDX_D;
        endcase
        return idx;
    endfunction

    // address decode shared by the write and read paths
    // so both paths always agree on which register an offset means
    always_comb begin
        wr_en        = ce_i && reg_wr_i;
        sel_swing    = (reg_addr_i == RBLS_OFS_SWING);
        sel_bw       = in_bank(reg_addr_i, RBLS_OFS_BW_A, RBLS_OFS_BW_D);
        sel_loss     = in_bank(reg_addr_i, RBLS_OFS_LOSS_A, RBLS_OFS_LOSS_D);
        sel_eff_bw   = (reg_addr_i == RBLS_OFS_EFF_BW);
        sel_eff_loss = (reg_addr_i == RBLS_OFS_EFF_LOSS);
    end

    // two flip-flops on the asynchronous pins before any logic reads them
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_meta_r <= 2'b00;
            pin_sync_r <= 2'b00;
        end else if (ce_i) begin
            pin_meta_r <= {speed_pin_upper_i, speed_pin_lower_i};
            pin_sync_r <= pin_meta_r;
        end
    end

    // swing register write; read-only and unmapped offsets never match a select
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            swing_r <= RBLS_SWING_RST;
        end else if (wr_en && sel_swing) begin
            swing_r <= reg_wdata_i;
        end
    end

    // bandwidth bank write; the low address bits pick the slot register
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < RBLS_SLOTS; i++) begin
                bw_slot_r[i] <= RBLS_SLOT_RST;
            end
        end else if (wr_en && sel_bw) begin
            bw_slot_r[reg_addr_i[1:0]] <= reg_wdata_i;
        end
    end

    // loss level bank write; the low address bits pick the slot register
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < RBLS_SLOTS; i++) begin
                loss_slot_r[i] <= RBLS_SLOT_RST;
            end
        end else if (wr_en && sel_loss) begin
            loss_slot_r[reg_addr_i[1:0]] <= reg_wdata_i;
        end
    end

    // slot choice and override handling, re-evaluated every cycle
    always_comb begin
        slot     = pin_slot(pin_sync_r);
        bank_idx = slot_idx(slot);
        bw_sel   = bw_slot_r[bank_idx];
        loss_sel = loss_slot_r[bank_idx];
        case (slot)
            RBLS_SLOT_A: begin
                bw_def_nxt   = RBLS_BW_DEF_A;
                loss_def_nxt = RBLS_LOSS_DEF_A;
            end
            RBLS_SLOT_B: begin
                bw_def_nxt   = RBLS_BW_DEF_B;
                loss_def_nxt = RBLS_LOSS_DEF_B;
            end
            RBLS_SLOT_C: begin
                bw_def_nxt   = RBLS_BW_DEF_C;
                loss_def_nxt = RBLS_LOSS_DEF_C;
            end
            default: begin
                bw_def_nxt   = RBLS_BW_DEF_D;
                loss_def_nxt = RBLS_LOSS_DEF_D;
            end
        endcase
        // override set: low field chosen, else default code reported
        if (bw_sel[RBLS_OVR_BIT]) begin
            bw_nxt = bw_sel[RBLS_BW_W-1:0];
        end else begin
            bw_nxt = BW_DEF_CODE;
        end
        if (loss_sel[RBLS_OVR_BIT]) begin
            loss_nxt = loss_sel[RBLS_LOSS_W-1:0];
        end else begin
            loss_nxt = LOSS_DEF_CODE;
        end
    end

    // swing code to level
    always_comb begin
        case (swing_r[RBLS_SWING_W-1:0])
            RBLS_SWING_350: swing_mv_nxt = RBLS_MV_350;
            RBLS_SWING_850: swing_mv_nxt = RBLS_MV_850;
            default:        swing_mv_nxt = RBLS_MV_650;
        endcase
    end

    // chosen slot and its fixed defaults; reset shows slot A as the pins do
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            active_slot_o     <= RBLS_SLOT_A;
            bw_default_mhz_o  <= RBLS_BW_DEF_A;
            loss_default_mv_o <= RBLS_LOSS_DEF_A;
        end else if (ce_i) begin
            active_slot_o     <= slot;
            bw_default_mhz_o  <= bw_def_nxt;
            loss_default_mv_o <= loss_def_nxt;
        end
    end

    // effective bandwidth code and its default flag
    // both come from the same chosen register, so they never disagree
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            effective_bw_field_o <= '0;
            bw_default_o         <= 1'b1;
        end else if (ce_i) begin
            effective_bw_field_o <= bw_nxt;
            bw_default_o         <= ~bw_sel[RBLS_OVR_BIT];
        end
    end

    // effective loss level code and its default flag
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            effective_loss_level_field_o <= '0;
            loss_default_o               <= 1'b1;
        end else if (ce_i) begin
            effective_loss_level_field_o <= loss_nxt;
            loss_default_o               <= ~loss_sel[RBLS_OVR_BIT];
        end
    end

    // swing code and level; both follow the swing register one edge later
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            swing_code_o <= RBLS_SWING_350;
            swing_mv_o   <= RBLS_MV_350;
        end else if (ce_i) begin
            swing_code_o <= swing_r[RBLS_SWING_W-1:0];
            swing_mv_o   <= swing_mv_nxt;
        end
    end

    // read mux; unmapped offsets and the unused upper bits of the effective fields read zero
    always_comb begin
        rdata_nxt = RBLS_RD_ZERO;
        if (sel_swing) begin
            rdata_nxt = swing_r;
        end else if (sel_bw) begin
            rdata_nxt = bw_slot_r[reg_addr_i[1:0]];
        end else if (sel_loss) begin
            rdata_nxt = loss_slot_r[reg_addr_i[1:0]];
        end else if (sel_eff_bw) begin
            rdata_nxt = {{(8-RBLS_BW_W){1'b0}}, effective_bw_field_o};
        end else if (sel_eff_loss) begin
            rdata_nxt = {{(8-RBLS_LOSS_W){1'b0}}, effective_loss_level_field_o};
        end
    end

    // read data register
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= RBLS_RD_ZERO;
        end else if (ce_i) begin
            reg_rdata_o <= rdata_nxt;
        end
    end

endmodule

`default_nettype wire

// ===== design/rbls_pkg.sv
// package: offsets, field layouts, defaults and slot codes for the rate select block
package rbls_pkg;
    // register offsets on the configuration port
    localparam logic [7:0] RBLS_OFS_SWING    = 8'h03;
    localparam logic [7:0] RBLS_OFS_BW_A     = 8'h04;
    localparam logic [7:0] RBLS_OFS_BW_D     = 8'h07;
    localparam logic [7:0] RBLS_OFS_LOSS_A   = 8'h08;
    localparam logic [7:0] RBLS_OFS_LOSS_D   = 8'h0B;
    localparam logic [7:0] RBLS_OFS_EFF_BW   = 8'h0E;
    localparam logic [7:0] RBLS_OFS_EFF_LOSS = 8'h0F;
    // field layout
    localparam int RBLS_OVR_BIT    = 7;
    localparam int RBLS_BW_W       = 4;
    localparam int RBLS_LOSS_W     = 7;
    localparam int RBLS_SWING_W    = 2;
    localparam int RBLS_SLOTS      = 4;
    // reset values
    localparam logic [7:0] RBLS_SLOT_RST  = 8'h00;
    localparam logic [7:0] RBLS_SWING_RST = 8'h00;
    localparam logic [7:0] RBLS_RD_ZERO   = 8'h00;
    // output swing codes and levels in mVpp
    localparam logic [1:0] RBLS_SWING_350 = 2'b00;
    localparam logic [1:0] RBLS_SWING_850 = 2'b11;
    localparam logic [9:0] RBLS_MV_350    = 10'h15E;
    localparam logic [9:0] RBLS_MV_650    = 10'h28A;
    localparam logic [9:0] RBLS_MV_850    = 10'h352;
    // fixed default bandwidths in MHz
    localparam logic [13:0] RBLS_BW_DEF_A = 14'h0960;
    localparam logic [13:0] RBLS_BW_DEF_B = 14'h1DB0;
    localparam logic [13:0] RBLS_BW_DEF_C = 14'h20D0;
    localparam logic [13:0] RBLS_BW_DEF_D = 14'h2328;
    // fixed default loss assert levels in mVpp
    localparam logic [5:0] RBLS_LOSS_DEF_A = 6'h0F;
    localparam logic [5:0] RBLS_LOSS_DEF_B = 6'h12;
    localparam logic [5:0] RBLS_LOSS_DEF_C = 6'h1A;
    localparam logic [5:0] RBLS_LOSS_DEF_D = 6'h1A;
    // bank register index of each slot, in address order A, B, C, D
    localparam logic [1:0] RBLS_IDX_A = 2'h0;
    localparam logic [1:0] RBLS_IDX_B = 2'h1;
    localparam logic [1:0] RBLS_IDX_C = 2'h2;
    localparam logic [1:0] RBLS_IDX_D = 2'h3;
    // slot picked by {speed_pin_upper, speed_pin_lower}
    typedef enum logic [1:0] {
        RBLS_SLOT_A = 2'b00,
        RBLS_SLOT_B = 2'b01,
        RBLS_SLOT_D = 2'b10,
        RBLS_SLOT_C = 2'b11
    } rbls_slot_e;
endpackage

// ===== verification/rbls_rate_select_asserts.sv
// checker: port-level relations of the rate select block
`timescale 1ns/1ps
`default_nettype none
module rbls_rate_select_asserts
    import rbls_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic        ce_i,
    input wire logic        speed_pin_upper_i,
    input wire logic        speed_pin_lower_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic [1:0]  swing_code_o,
    input wire logic [9:0]  swing_mv_o,
    input wire logic [3:0]  effective_bw_field_o,
    input wire logic [6:0]  effective_loss_level_field_o,
    input wire logic [13:0] bw_default_mhz_o,
    input wire logic [5:0]  loss_default_mv_o,
    input wire logic [1:0]  active_slot_o
);
    // one clock domain, reset disables every check
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    swing_low_a: assert property (swing_code_o == 2'b00 |-> swing_mv_o == 10'h15E)
        else $error("swing level wrong for code 00");
    swing_mid_a: assert property (swing_code_o inside {2'b01, 2'b10} |-> swing_mv_o == 10'h28A)
        else $error("swing level wrong for middle codes");
    swing_top_a: assert property (swing_code_o == 2'b11 |-> swing_mv_o == 10'h352)
        else $error("swing level wrong for code 11");
    slot_a_def_a: assert property (active_slot_o == 2'b00 |-> bw_default_mhz_o == 14'h0960 && loss_default_mv_o == 6'h0F)
        else $error("slot a defaults wrong");
    slot_b_def_a: assert property (active_slot_o == 2'b01 |-> bw_default_mhz_o == 14'h1DB0 && loss_default_mv_o == 6'h12)
        else $error("slot b defaults wrong");
    slot_c_def_a: assert property (active_slot_o == 2'b11 |-> bw_default_mhz_o == 14'h20D0 && loss_default_mv_o == 6'h1A)
        else $error("slot c defaults wrong");
    slot_d_def_a: assert property (active_slot_o == 2'b10 |-> bw_default_mhz_o == 14'h2328 && loss_default_mv_o == 6'h1A)
        else $error("slot d defaults wrong");
    pin_slot_a: assert property ($past(reset_n_i, 3) && $past(ce_i) && $past(ce_i, 2) && $past(ce_i, 3)
        |-> active_slot_o == $past({speed_pin_upper_i, speed_pin_lower_i}, 3))
        else $error("slot does not follow pins");
    bw_read_a: assert property ($past(ce_i) && $past(reg_addr_i) == 8'h0E |-> reg_rdata_o == {4'h0, $past(effective_bw_field_o)})
        else $error("effective bandwidth readback wrong");
    loss_read_a: assert property ($past(ce_i) && $past(reg_addr_i) == 8'h0F
        |-> reg_rdata_o == {1'b0, $past(effective_loss_level_field_o)})
        else $error("effective loss readback wrong");
endmodule
bind rbls_rate_select rbls_rate_select_asserts u_asserts (.*);
`default_nettype wire

// ===== verification/rbls_host_model.sv
// host model: byte writes and reads on the register port
`timescale 1ns/1ps
`default_nettype none
module rbls_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output var logic  [7:0] addr_o,
    output var logic        wr_o,
    output var logic  [7:0] wdata_o
);
    // idle port at time zero
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'hA5;
    end
    // one byte write, held up to the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wr_o = 1'b1;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        wdata_o = ~d; // released data shows no stale value
    endtask
    // one byte read, data one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// ===== verification/rbls_rate_select_tb_top.sv
// testbench: drives the rate select block through its pins and register port
`timescale 1ns/1ps
`default_nettype none
module rbls_rate_select_tb_top
    import rbls_pkg::*;
;
    logic ref_clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1;
    logic speed_pin_upper_i = 1'b0, speed_pin_lower_i = 1'b0;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic reg_wr_i, bw_default_o, loss_default_o;
    logic [1:0] swing_code_o, active_slot_o;
    logic [9:0] swing_mv_o;
    logic [3:0] effective_bw_field_o;
    logic [6:0] effective_loss_level_field_o;
    logic [13:0] bw_default_mhz_o;
    logic [5:0] loss_default_mv_o;
    int n_fail = 0, n_checks = 0;
    // 20 MHz clock
    always #25 ref_clk_i = ~ref_clk_i;
    rbls_rate_select u_dut (.*);
    rbls_host_model u_host (.clk_i(ref_clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
        .wr_o(reg_wr_i), .wdata_o(reg_wdata_i));
    // compare one result
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // every swing code
    task automatic t_swing();
        logic [9:0] lv [4] = '{10'h15E, 10'h28A, 10'h28A, 10'h352};
        for (int c = 0; c < 4; c++) begin
            u_host.wr(8'h03, 8'(c));
            repeat (3) @(posedge ref_clk_i);
            #1;
            chk({swing_code_o, 4'h0, swing_mv_o}, {2'(c), 4'h0, lv[c]});
        end
        $display("swing test done");
    endtask
    // each pin pair: defaults, then overrides and readback
    task automatic t_slots();
        logic [7:0] ofs [4] = '{8'h04, 8'h05, 8'h07, 8'h06};
        logic [7:0] signal_loss [4] = '{8'h80, 8'hFF, 8'hA5, 8'hDA};
        logic [13:0] bm [4] = '{14'h0960, 14'h1DB0, 14'h2328, 14'h20D0};
        logic [5:0] lm [4] = '{6'h0F, 6'h12, 6'h1A, 6'h1A};
        logic [7:0] d;
        for (int p = 0; p < 4; p++) begin
            {speed_pin_upper_i, speed_pin_lower_i} = 2'(p);
            repeat (4) @(posedge ref_clk_i);
            #1;
            chk(16'(active_slot_o), 16'(p));
            chk({bw_default_o, loss_default_o, bw_default_mhz_o}, {2'b11, bm[p]});
            chk(16'(loss_default_mv_o), 16'(lm[p]));
            u_host.wr(ofs[p], 8'h80 | 8'(p + 9));
            u_host.wr(ofs[p] + 8'h04, signal_loss[p]);
            repeat (3) @(posedge ref_clk_i);
            #1;
            chk({bw_default_o, loss_default_o, 3'b0, effective_loss_level_field_o, effective_bw_field_o},
                {5'b0, signal_loss[p][6:0], 4'(p + 9)});
            u_host.rd(8'h0E, d);
            chk(16'(d), 16'(p + 9));
            u_host.rd(8'h0F, d);
            chk(16'(d), 16'(signal_loss[p][6:0]));
        end
        {speed_pin_upper_i, speed_pin_lower_i} = 2'b00;
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk(16'(effective_bw_field_o), 16'h0009);
        $display("slot test done");
    endtask
    // read-only, unmapped and frozen writes are refused
    task automatic t_refuse();
        logic [7:0] d;
        u_host.wr(8'h0E, 8'hFF);
        u_host.wr(8'h2C, 8'h5A);
        u_host.rd(8'h2C, d);
        chk(16'(d), 16'h0000);
        u_host.rd(8'h0E, d);
        chk(16'(d), 16'h0009);
        ce_i = 1'b0;
        u_host.wr(8'h04, 8'h83);
        ce_i = 1'b1;
        u_host.rd(8'h04, d);
        chk(16'(d), 16'h0089);
        $display("refuse test done");
    endtask
    // reset in mid-run: registers clear and the fixed defaults return
    task automatic t_reset();
        logic [7:0] d;
        reset_n_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk({bw_default_o, loss_default_o, 14'h0000}, 16'hC000);
        chk({5'h00, effective_loss_level_field_o, effective_bw_field_o}, 16'h0000);
        chk({swing_code_o, 4'h0, swing_mv_o}, {2'b00, 4'h0, 10'h15E});
        reset_n_i = 1'b1;
        u_host.rd(8'h04, d);
        chk(16'(d), 16'h0000);
        u_host.rd(8'h08, d);
        chk(16'(d), 16'h0000);
        chk({2'b00, bw_default_mhz_o}, 16'h0960);
        chk(16'(loss_default_mv_o), 16'h000F);
        $display("reset test done");
    endtask
    // counts and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(posedge ref_clk_i);
        #1;
        reset_n_i = 1'b1;
        t_swing();
        t_slots();
        t_refuse();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
